// file: src/tlec_regs.vh
// register offsets, reset values and bit positions of the thermal limit
// and eeprom control register bank; no process, definitions only
`ifndef TLEC_REGS_VH
`define TLEC_REGS_VH

// offsets printed for the bank
`define TLEC_OFS_REMOTE1_ALARM_LIMIT 8'h0e
`define TLEC_OFS_REMOTE2_ALARM_LIMIT 8'h0f
`define TLEC_OFS_INTERNAL_FAN_START 8'h10
`define TLEC_OFS_REMOTE1_FAN_START 8'h11
// offsets in the gaps around the printed ones
`define TLEC_OFS_FACTORY_RESERVED 8'h0c
`define TLEC_OFS_INTERNAL_ALARM_LIMIT 8'h0d
`define TLEC_OFS_REMOTE2_FAN_START 8'h12
`define TLEC_OFS_EEPROM_CONTROL 8'h13

// power-on values, one degree per lsb
`define TLEC_RST_INTERNAL_ALARM_LIMIT 8'h37
`define TLEC_RST_REMOTE_ALARM_LIMIT 8'h50
`define TLEC_RST_INTERNAL_FAN_START 8'h28
`define TLEC_RST_REMOTE_FAN_START 8'h40
`define TLEC_RST_FACTORY_RESERVED 8'h00
`define TLEC_RST_EEPROM_CONTROL 8'h00

// eeprom control bit positions
`define TLEC_EE_READ_BIT 0
`define TLEC_EE_PROGRAM_BIT 1
`define TLEC_EE_ERASE_BIT 2
`define TLEC_EE_PROTECT_BIT 3
`define TLEC_EE_CLOCK_EXTEND_BIT 7

`endif

// file: src/tlec_limit_cmp.v
// one channel's limit compare: reading above limit, registered
// assumes reading and limit are unsigned degrees at one per lsb
`default_nettype none
`timescale 1ns/1ps

module tlec_limit_cmp #(
  parameter WIDTH = 8
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire [WIDTH-1:0] reading_i,
  input wire [WIDTH-1:0] limit_i,
  output reg above_o
);

  // strict greater-than: equal to the limit is not an alarm
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      above_o <= 1'b0;
    end else if (clk_en_i) begin
      above_o <= (reading_i > limit_i);
    end
  end

endmodule // tlec_limit_cmp
`default_nettype wire

// file: src/tlec_bank.v
// thermal limit and eeprom control register bank
// assumes the serial bus engine presents byte accesses as a one-cycle
// write strobe or read strobe with an 8-bit register pointer, and that
// sys_rst_i is the power-on reset
//
// Functional notes
// - alarm output asserts when internal temperature exceeds its limit, reset 55.
// - alarm output asserts when remote diode one exceeds limit at 0x0e, reset 80.
// - alarm output asserts when remote diode two exceeds limit at 0x0f, reset 80.
// - register 0x10 is internal fan start temperature, reset 40.
// - register 0x11 is remote diode one fan start temperature, reset 64.
// - separate register holds remote diode two fan start temperature, reset 64.
// - eeprom control bit 0 selects eeprom read mode.
// - eeprom control bit 1 selects eeprom programming mode.
// - eeprom control bit 2 selects eeprom erase mode.
// - while protect bit 3 is set, programming and erasure are refused.
// - protect bit is write-once; only power-on reset clears it.
// - with clock-extend set, device may hold serial clock when busy.
`include "tlec_regs.vh"
`default_nettype none
`timescale 1ns/1ps

module tlec_bank #(
  parameter TEMP_W = 8
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [TEMP_W-1:0] internal_temp_i,
  input wire [TEMP_W-1:0] remote_diode_one_temp_i,
  input wire [TEMP_W-1:0] remote_diode_two_temp_i,
  input wire eeprom_busy_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  output reg thermal_alarm_output_o,
  output reg [TEMP_W-1:0] internal_fan_start_temperature_o,
  output reg [TEMP_W-1:0] remote_diode_one_fan_start_temperature_o,
  output reg [TEMP_W-1:0] remote_diode_two_fan_start_temperature_o,
  output reg eeprom_read_mode_o,
  output reg eeprom_program_mode_o,
  output reg eeprom_erase_mode_o,
  output reg serial_clock_hold_o
);

  ////////////////////////////////////////////////////////////////////////
  // register storage

  reg [7:0] internal_alarm_limit_q;
  reg [7:0] remote1_alarm_limit_q;
  reg [7:0] remote2_alarm_limit_q;
  reg [7:0] eeprom_control_q;
  reg [7:0] eeprom_control_d;
  wire factory_sel;
  wire int_above;
  wire r1_above;
  wire r2_above;

  // address match helper, used by every decode below
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // factory byte has no write path at all
  assign factory_sel = hit(reg_addr_i, `TLEC_OFS_FACTORY_RESERVED);

  // next eeprom control value: protect is sticky once set
  always @* begin
    eeprom_control_d = eeprom_control_q;
    if (reg_wr_i && hit(reg_addr_i, `TLEC_OFS_EEPROM_CONTROL)) begin
      eeprom_control_d = reg_wdata_i;
      // set wins, clear is ignored after the first set
      eeprom_control_d[`TLEC_EE_PROTECT_BIT] =
        eeprom_control_q[`TLEC_EE_PROTECT_BIT] | reg_wdata_i[`TLEC_EE_PROTECT_BIT];
    end
  end

  // limit, start temperature and control writes
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      internal_alarm_limit_q <= `TLEC_RST_INTERNAL_ALARM_LIMIT;
      remote1_alarm_limit_q <= `TLEC_RST_REMOTE_ALARM_LIMIT;
      remote2_alarm_limit_q <= `TLEC_RST_REMOTE_ALARM_LIMIT;
      internal_fan_start_temperature_o <= `TLEC_RST_INTERNAL_FAN_START;
      remote_diode_one_fan_start_temperature_o <= `TLEC_RST_REMOTE_FAN_START;
      remote_diode_two_fan_start_temperature_o <= `TLEC_RST_REMOTE_FAN_START;
      eeprom_control_q <= `TLEC_RST_EEPROM_CONTROL;
    end else if (clk_en_i) begin
      eeprom_control_q <= eeprom_control_d;
      if (reg_wr_i) begin
        if (hit(reg_addr_i, `TLEC_OFS_INTERNAL_ALARM_LIMIT)) begin
          internal_alarm_limit_q <= reg_wdata_i;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE1_ALARM_LIMIT)) begin
          remote1_alarm_limit_q <= reg_wdata_i;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE2_ALARM_LIMIT)) begin
          remote2_alarm_limit_q <= reg_wdata_i;
        end else if (hit(reg_addr_i, `TLEC_OFS_INTERNAL_FAN_START)) begin
          internal_fan_start_temperature_o <= reg_wdata_i;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE1_FAN_START)) begin
          remote_diode_one_fan_start_temperature_o <= reg_wdata_i;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE2_FAN_START)) begin
          remote_diode_two_fan_start_temperature_o <= reg_wdata_i;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data registered one cycle after the strobe

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else if (clk_en_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (factory_sel) begin
          reg_rdata_o <= `TLEC_RST_FACTORY_RESERVED;
        end else if (hit(reg_addr_i, `TLEC_OFS_INTERNAL_ALARM_LIMIT)) begin
          reg_rdata_o <= internal_alarm_limit_q;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE1_ALARM_LIMIT)) begin
          reg_rdata_o <= remote1_alarm_limit_q;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE2_ALARM_LIMIT)) begin
          reg_rdata_o <= remote2_alarm_limit_q;
        end else if (hit(reg_addr_i, `TLEC_OFS_INTERNAL_FAN_START)) begin
          reg_rdata_o <= internal_fan_start_temperature_o;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE1_FAN_START)) begin
          reg_rdata_o <= remote_diode_one_fan_start_temperature_o;
        end else if (hit(reg_addr_i, `TLEC_OFS_REMOTE2_FAN_START)) begin
          reg_rdata_o <= remote_diode_two_fan_start_temperature_o;
        end else if (hit(reg_addr_i, `TLEC_OFS_EEPROM_CONTROL)) begin
          reg_rdata_o <= eeprom_control_q;
        end else begin
          reg_rdata_o <= 8'h00; // unmapped reads as zero
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm compares, one per channel

  tlec_limit_cmp #(.WIDTH(TEMP_W)) u_int_cmp (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .reading_i(internal_temp_i),
    .limit_i(internal_alarm_limit_q[TEMP_W-1:0]),
    .above_o(int_above)
  );

  tlec_limit_cmp #(.WIDTH(TEMP_W)) u_r1_cmp (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .reading_i(remote_diode_one_temp_i),
    .limit_i(remote1_alarm_limit_q[TEMP_W-1:0]),
    .above_o(r1_above)
  );

  tlec_limit_cmp #(.WIDTH(TEMP_W)) u_r2_cmp (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .reading_i(remote_diode_two_temp_i),
    .limit_i(remote2_alarm_limit_q[TEMP_W-1:0]),
    .above_o(r2_above)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs: alarm, eeprom modes, clock hold

  // extra register stage keeps every output straight from a flop
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      thermal_alarm_output_o <= 1'b0;
      eeprom_read_mode_o <= 1'b0;
      eeprom_program_mode_o <= 1'b0;
      eeprom_erase_mode_o <= 1'b0;
      serial_clock_hold_o <= 1'b0;
    end else if (clk_en_i) begin
      thermal_alarm_output_o <= int_above | r1_above | r2_above;
      eeprom_read_mode_o <= eeprom_control_q[`TLEC_EE_READ_BIT];
      // protect gates program and erase, read stays usable
      eeprom_program_mode_o <= eeprom_control_q[`TLEC_EE_PROGRAM_BIT] &
        ~eeprom_control_q[`TLEC_EE_PROTECT_BIT];
      eeprom_erase_mode_o <= eeprom_control_q[`TLEC_EE_ERASE_BIT] &
        ~eeprom_control_q[`TLEC_EE_PROTECT_BIT];
      serial_clock_hold_o <= eeprom_control_q[`TLEC_EE_CLOCK_EXTEND_BIT] & eeprom_busy_i;
    end
  end

endmodule // tlec_bank
`default_nettype wire

// file: dv/tlec_bank_asserts.sv
// port checker for the thermal limit register bank
// assumes one clock domain; writes count only while clk_en_i is high
`timescale 1ns/1ps
`default_nettype none
module tlec_bank_chk (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] internal_temp_i,
  input wire logic [7:0] remote_diode_one_temp_i,
  input wire logic [7:0] remote_diode_two_temp_i,
  input wire logic eeprom_busy_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic thermal_alarm_output_o,
  input wire logic [7:0] internal_fan_start_temperature_o,
  input wire logic eeprom_read_mode_o,
  input wire logic eeprom_program_mode_o,
  input wire logic eeprom_erase_mode_o,
  input wire logic serial_clock_hold_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic prot_q;
  logic ext_q;
  wire ctl_wr = clk_en_i && reg_wr_i && reg_addr_i == 8'h13;
  wire cold = internal_temp_i == 8'h00 && remote_diode_one_temp_i == 8'h00 && remote_diode_two_temp_i == 8'h00;
  wire fan_wr = clk_en_i && reg_wr_i && reg_addr_i == 8'h10;
  ////////////////////////////////////////
  // shadow of protect and extend bits; protect sticks until reset
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prot_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (ctl_wr) begin
      prot_q <= prot_q | reg_wdata_i[3];
      ext_q <= reg_wdata_i[7];
    end
  end
  a_rvalid_follows_read: assert property (reg_rvalid_o == $past(reg_rd_i)) else $error("rvalid wrong");
  a_rdata_held: assert property ($changed(reg_rdata_o) |-> reg_rvalid_o) else $error("rdata moved");
  a_factory_reads_zero:
    assert property (reg_rd_i && reg_addr_i == 8'h0c |=> reg_rdata_o == 8'h00) else $error("factory nonzero");
  a_fan_write_lands:
    assert property (fan_wr |=> internal_fan_start_temperature_o == $past(reg_wdata_i)) else $error("fan start");
  a_fan_stays_put:
    assert property (!fan_wr |=> $stable(internal_fan_start_temperature_o)) else $error("fan moved");
  a_cold_no_alarm:
    assert property (cold [*3] |-> !thermal_alarm_output_o) else $error("alarm when cold");
  a_read_mode_follows:
    assert property (ctl_wr ##1 !ctl_wr |=> eeprom_read_mode_o == $past(reg_wdata_i[0], 2)) else $error("read mode");
  a_program_mode_gated:
    assert property (ctl_wr ##1 !ctl_wr |=> eeprom_program_mode_o == ($past(reg_wdata_i[1], 2) && !$past(prot_q)))
      else $error("program mode");
  a_erase_mode_gated:
    assert property (ctl_wr ##1 !ctl_wr |=> eeprom_erase_mode_o == ($past(reg_wdata_i[2], 2) && !$past(prot_q)))
      else $error("erase mode");
  a_clock_hold_busy:
    assert property (serial_clock_hold_o == $past(ext_q && eeprom_busy_i)) else $error("clock hold");
  c_alarm: cover property (thermal_alarm_output_o);
  c_hold: cover property (serial_clock_hold_o);
  c_protect: cover property (prot_q && ctl_wr);
endmodule // tlec_bank_chk
bind tlec_bank tlec_bank_chk tlec_bank_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .internal_temp_i(internal_temp_i),
  .remote_diode_one_temp_i(remote_diode_one_temp_i), .remote_diode_two_temp_i(remote_diode_two_temp_i),
  .eeprom_busy_i(eeprom_busy_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .thermal_alarm_output_o(thermal_alarm_output_o),
  .internal_fan_start_temperature_o(internal_fan_start_temperature_o), .eeprom_read_mode_o(eeprom_read_mode_o),
  .eeprom_program_mode_o(eeprom_program_mode_o), .eeprom_erase_mode_o(eeprom_erase_mode_o),
  .serial_clock_hold_o(serial_clock_hold_o));
`default_nettype wire

// file: dv/tlec_ee_model.sv
// eeprom array stand-in: busy while a write-type mode is on
// assumes the bank's clock
`timescale 1ns/1ps
`default_nettype none
module tlec_ee_model (
  input wire logic mclk_i,
  input wire logic prog_i,
  input wire logic erase_i,
  output logic busy_o = 1'b0
);
  // busy lags the mode by a cycle, as an array would
  always @(posedge mclk_i) busy_o <= prog_i | erase_i;
endmodule // tlec_ee_model
`default_nettype wire

// file: dv/tlec_bank_tb_top.sv
// self-checking bench for the register bank
// assumes the eeprom stand-in model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tlec_bank_tb_top;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic en = 1'b1;
  wire [7:0] f0, f1, f2;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] tp [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] expq [$];
  logic [7:0] e;
  logic [31:0] lfsr = 32'hdbdf;
  wire [7:0] rdata;
  wire rvalid, alarm, rm, pm, em, hold, busy;
  int checked = 0;
  int mismatches = 0;
  int cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  tlec_bank tlec_bank_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd_s), .internal_temp_i(tp[0]), .remote_diode_one_temp_i(tp[1]),
    .remote_diode_two_temp_i(tp[2]), .eeprom_busy_i(busy), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .thermal_alarm_output_o(alarm), .internal_fan_start_temperature_o(f0),
    .remote_diode_one_fan_start_temperature_o(f1),
    .remote_diode_two_fan_start_temperature_o(f2), .eeprom_read_mode_o(rm), .eeprom_program_mode_o(pm),
    .eeprom_erase_mode_o(em), .serial_clock_hold_o(hold));
  tlec_ee_model tlec_ee_model_inst (.mclk_i(mclk_i), .prog_i(pm), .erase_i(em), .busy_o(busy));
  ////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // each access is two cycles so a strobe is never set twice in one step
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdt(input logic [7:0] a, input logic [7:0] x);
    addr <= a;
    rd_s <= 1'b1;
    expq.push_back(x);
    @(posedge mclk_i);
    rd_s <= 1'b0;
    @(posedge mclk_i);
  endtask
  // mode pins and hold after a control write, hold lags by the array
  task automatic ctl(input logic [7:0] d, input logic [3:0] x);
    wrt(8'h13, d);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("modes", x, {rm, pm, em, hold})
    @(posedge mclk_i);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read answers are matched against the oldest note
  always @(posedge mclk_i) begin
    cyc++;
    if (rvalid === 1'b1) begin
      e = expq.pop_front();
      `CHK("rdata", e, rdata)
    end
    if (cyc == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 8; i++)
      rdt(8'h0c + i, i == 1 ? 8'h37 : i < 4 ? 8'h50 >> (i == 0) * 8 : i == 4 ? 8'h28 : i < 7 ? 8'h40 : 8'h00);
    $display("test defaults done");
    for (int i = 1; i < 7; i++) begin
      lfsr = nx(lfsr);
      wrt(8'h0c + i, lfsr[7:0]);
      rdt(8'h0c + i, lfsr[7:0]);
    end
    wrt(8'h0c, lfsr[15:8]);
    rdt(8'h0c, 8'h00);
    rdt(8'h20, 8'h00);
    // start temperature ports show the register itself once the write lands
    wrt(8'h10, 8'h3c);
    `CHK("fan0", 8'h3c, f0)
    wrt(8'h11, 8'h5a);
    `CHK("fan1", 8'h5a, f1)
    wrt(8'h12, 8'ha5);
    `CHK("fan2", 8'ha5, f2)
    // a write while the clock enable is low must not land
    en <= 1'b0;
    wrt(8'h12, 8'h11);
    en <= 1'b1;
    `CHK("fan2 frozen", 8'ha5, f2)
    $display("test access done");
    // limit equal must stay quiet, one above must alarm
    for (int c = 0; c < 3; c++) begin
      lfsr = nx(lfsr);
      wrt(8'h0d + c, {1'b0, lfsr[6:0]});
      tp[c] <= {1'b0, lfsr[6:0]};
      repeat (3) @(posedge mclk_i);
      `CHK("alarm", 1'b0, alarm)
      tp[c] <= {1'b0, lfsr[6:0]} + 8'h01;
      repeat (3) @(posedge mclk_i);
      `CHK("alarm", 1'b1, alarm)
      tp[c] <= 8'h00;
    end
    $display("test alarm done");
    ctl(8'h87, 4'b1111);
    ctl(8'h0b, 4'b1000);
    ctl(8'h00, 4'b0000);
    rdt(8'h13, 8'h08);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rdt(8'h13, 8'h00);
    $display("test eeprom done");
    repeat (4) @(posedge mclk_i);
    report_and_stop();
  end
endmodule // tlec_bank_tb_top
`default_nettype wire
